/* common/fsg_pkg.sv */
// Package for the flash section write guard: sizes, section codes and request structs
package fsg_pkg;

  // ==========================================================================
  // Flash geometry
  // ==========================================================================
  localparam int unsigned FLASH_BYTES      = 32'h0000_8000;     // 32 KB array
  localparam int unsigned ADDR_W           = 15;
  localparam int unsigned PAGE_BYTES       = 32'h0000_0200;     // 512-byte erase page
  localparam int unsigned PAGE_SHIFT       = 9;
  localparam int unsigned FUSE_W           = 8;
  localparam logic [ADDR_W-1:0] LAST_FLASH_ADDRESS = 15'h7fff;
  localparam logic [ADDR_W-1:0] FIRST_FLASH_ADDRESS = 15'h0000;
  localparam int unsigned ERASE_PAGES_W    = 6;                  // Up to 63 pages at once

  // Default fuse values used when a boundary overruns the array
  localparam logic [FUSE_W-1:0] LOADER_SIZE_DEFAULT = 8'h00;
  localparam logic [FUSE_W-1:0] CODE_SIZE_DEFAULT   = 8'h00;

  // ==========================================================================
  // Sections (one-hot)
  // ==========================================================================
  typedef enum logic [2:0] {
    FSG_SEC_LOADER = 3'b001,
    FSG_SEC_CODE   = 3'b010,
    FSG_SEC_DATA   = 3'b100
  } fsg_section_e;

  // Request kinds
  typedef enum logic [2:0] {
    FSG_OP_WRITE  = 3'b001,
    FSG_OP_ERASE  = 3'b010,
    FSG_OP_EEPROM = 3'b100
  } fsg_op_e;

  // Guard states
  typedef enum logic [1:0] {
    FSG_ST_IDLE = 2'b01,
    FSG_ST_BUSY = 2'b10
  } fsg_state_e;

  // Processor write/erase request
  typedef struct packed {
    fsg_op_e                  op;
    logic [ADDR_W-1:0]        addr;
    logic [15:0]              wdata;
    logic                     word;       // 1: word write, 0: byte write
    logic [ERASE_PAGES_W-1:0] pages;      // Erase page count, 0 treated as 1
  } fsg_req_s;

  // Command to the flash array or EEPROM
  typedef struct packed {
    fsg_op_e                  op;
    logic [ADDR_W-1:0]        addr;
    logic [15:0]              wdata;
    logic                     word;
    logic [ERASE_PAGES_W-1:0] pages;
  } fsg_cmd_s;

endpackage : fsg_pkg

/* verilog/fsg_guard.sv */
// Flash section write guard: partitions flash and filters self-programming requests
// Overview of operation
// - Flash is organised in 512-byte pages; a page is the least erasable unit.
// - Erase acts on whole pages only; programming works per byte or word.
// - A flash write into the section code is fetched from is refused.
// - Application code section is writable only from code in the loader section.
// - Application data section is writable from loader or application code sections.
// - Permitted flash writes halt the processor; EEPROM writes do not; data section programs nothing.
// - Loader and code section sizes come from two fuses, in 512-byte blocks.
// - Loader from start to loader end, code up to code end, rest is data.
// - Loader size fuse zero makes the whole flash the loader section.
// - Code fuse zero with loader nonzero: code section runs to flash end.
// - Code fuse not above loader fuse: no code section, data from loader end.
// - A fuse whose boundary passes the last flash address falls back to its default.
// - Vectors sit at code section start after reset; select bit moves them to loader.
`timescale 1ns/1ps

module fsg_guard
  import fsg_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // Size fuses, sampled once after reset
  input  wire logic [FUSE_W-1:0]      loader_size_fuse,
  input  wire logic [FUSE_W-1:0]      code_region_size_fuse,
  // Processor side
  input  wire logic [ADDR_W-1:0]      fetch_addr,
  input  wire logic                   vector_table_select,
  input  wire logic                   req_valid,
  input  wire fsg_req_s               req,
  output logic                        req_ready,
  output logic                        req_refused,
  output logic                        cpu_halt,
  output logic [ADDR_W-1:0]           vector_base,
  // Flash array and EEPROM side
  output logic                        cmd_valid,
  output fsg_cmd_s                    cmd,
  input  wire logic                   cmd_done,
  // Partition view
  output logic [ADDR_W:0]             loader_end_boundary,
  output logic [ADDR_W:0]             code_end_boundary,
  output logic                        fuses_loaded
);

  // ==========================================================================
  // Fuse capture and boundary computation
  // ==========================================================================
  logic                  fuses_loaded_q;
  logic [ADDR_W:0]       loader_end_q;
  logic [ADDR_W:0]       code_end_q;
  logic [ADDR_W+FUSE_W:0] loader_raw;
  logic [ADDR_W+FUSE_W:0] code_raw;
  logic [FUSE_W-1:0]     loader_fuse_eff;
  logic [FUSE_W-1:0]     code_fuse_eff;
  localparam logic [ADDR_W+FUSE_W:0] FLASH_TOP = (ADDR_W+FUSE_W+1)'(FLASH_BYTES);

  // Boundaries in bytes from the fuses, with overrun fallback
  always_comb
  begin
    loader_raw = (ADDR_W+FUSE_W+1)'(loader_size_fuse) << PAGE_SHIFT;
    code_raw   = (ADDR_W+FUSE_W+1)'(code_region_size_fuse) << PAGE_SHIFT;
    loader_fuse_eff = (loader_raw > FLASH_TOP) ? LOADER_SIZE_DEFAULT : loader_size_fuse;
    code_fuse_eff   = (code_raw > FLASH_TOP) ? CODE_SIZE_DEFAULT : code_region_size_fuse;
  end

  // Partition fixed once at the first edge after reset release
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fuses_loaded_q <= 1'b0;
      loader_end_q   <= '0;
      code_end_q     <= '0;
    end
    else if (!fuses_loaded_q)
    begin
      fuses_loaded_q <= 1'b1;
      if (loader_fuse_eff == '0)
      begin
        loader_end_q <= (ADDR_W+1)'(FLASH_BYTES);
        code_end_q   <= (ADDR_W+1)'(FLASH_BYTES);
      end
      else if (code_fuse_eff == '0)
      begin
        loader_end_q <= (ADDR_W+1)'({loader_fuse_eff, 9'h000});
        code_end_q   <= (ADDR_W+1)'(FLASH_BYTES);
      end
      else if (code_fuse_eff <= loader_fuse_eff)
      begin
        loader_end_q <= (ADDR_W+1)'({loader_fuse_eff, 9'h000});
        code_end_q   <= (ADDR_W+1)'({loader_fuse_eff, 9'h000});
      end
      else
      begin
        loader_end_q <= (ADDR_W+1)'({loader_fuse_eff, 9'h000});
        code_end_q   <= (ADDR_W+1)'({code_fuse_eff, 9'h000});
      end
    end
  end

  assign loader_end_boundary = loader_end_q;
  assign code_end_boundary   = code_end_q;
  assign fuses_loaded        = fuses_loaded_q;

  // ==========================================================================
  // Section lookup
  // ==========================================================================
  function automatic fsg_section_e section_of(input logic [ADDR_W-1:0] a,
                                              input logic [ADDR_W:0]   le,
                                              input logic [ADDR_W:0]   ce);
    if ({1'b0, a} < le)
      section_of = FSG_SEC_LOADER;
    else if ({1'b0, a} < ce)
      section_of = FSG_SEC_CODE;
    else
      section_of = FSG_SEC_DATA;
  endfunction

  fsg_section_e exec_sec;
  fsg_section_e target_sec;
  logic [ADDR_W-1:0] target_addr;
  logic              permitted;

  // Decide whether a request may proceed
  always_comb
  begin
    exec_sec = section_of(fetch_addr, loader_end_q, code_end_q);
    target_addr = (req.op == FSG_OP_ERASE) ? {req.addr[ADDR_W-1:PAGE_SHIFT], 9'h000} : req.addr;
    target_sec  = section_of(target_addr, loader_end_q, code_end_q);
    permitted   = 1'b0;
    case (exec_sec)
      FSG_SEC_LOADER: permitted = (req.op == FSG_OP_EEPROM) || (target_sec != FSG_SEC_LOADER);
      FSG_SEC_CODE:   permitted = (req.op == FSG_OP_EEPROM) || (target_sec == FSG_SEC_DATA);
      FSG_SEC_DATA:   permitted = 1'b0;
      default:        permitted = 1'b0;
    endcase
    // never own section: covered by the table above for flash ops
  end

  // ==========================================================================
  // Request sequencing
  // ==========================================================================
  fsg_state_e state_q;
  logic       halt_q;
  logic       refused_q;
  fsg_cmd_s   cmd_q;

  // Requests accepted only while idle and partition is known
  assign req_ready = (state_q == FSG_ST_IDLE) && fuses_loaded_q;

  // State and halt
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= FSG_ST_IDLE;
      halt_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        FSG_ST_IDLE:
        begin
          // refused request: no command, no halt
          if (req_valid && req_ready && permitted)
          begin
            state_q <= FSG_ST_BUSY;
            halt_q  <= (req.op != FSG_OP_EEPROM);
          end
        end
        FSG_ST_BUSY:
        begin
          if (cmd_done)
          begin
            state_q <= FSG_ST_IDLE;
            halt_q  <= 1'b0;
          end
        end
        default:
        begin
          state_q <= FSG_ST_IDLE;
          halt_q  <= 1'b0;
        end
      endcase
    end
  end

  // Command register to the array, held through the busy phase
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cmd_q <= '{op: FSG_OP_WRITE, addr: '0, wdata: 16'h0000, word: 1'b0, pages: '0};
    else if (req_valid && req_ready && permitted)
    begin
      cmd_q       <= req;
      cmd_q.addr  <= target_addr;
      // word writes aligned, bit 0 ignored
      if (req.op == FSG_OP_WRITE && req.word)
        cmd_q.addr <= {target_addr[ADDR_W-1:1], 1'b0};
      cmd_q.pages <= (req.op == FSG_OP_ERASE && req.pages == '0) ? 6'h01 : req.pages;
    end
  end

  // Refusal pulse
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      refused_q <= 1'b0;
    else
      refused_q <= req_valid && req_ready && !permitted;
  end

  assign cmd_valid   = (state_q == FSG_ST_BUSY);
  assign cmd         = cmd_q;
  assign cpu_halt    = halt_q;
  assign req_refused = refused_q;

  // ==========================================================================
  // Vector table base
  // ==========================================================================
  logic [ADDR_W-1:0] vector_base_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      vector_base_q <= FIRST_FLASH_ADDRESS;
    else if (vector_table_select || loader_end_q[ADDR_W])
      vector_base_q <= FIRST_FLASH_ADDRESS;
    else
      vector_base_q <= loader_end_q[ADDR_W-1:0]; // Code section start
  end

  assign vector_base = vector_base_q;

endmodule // fsg_guard

/* test/fsg_guard_props.sv */
// Port checker for the flash section write guard
`timescale 1ns/1ps
module fsg_guard_props
  import fsg_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  // Request side
  input wire logic [FUSE_W-1:0] loader_size_fuse,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic              req_valid,
  input wire fsg_req_s          req,
  input wire logic              req_ready,
  input wire logic              req_refused,
  input wire logic              cpu_halt,
  // Array side and partition
  input wire logic              cmd_valid,
  input wire fsg_cmd_s          cmd,
  input wire logic              cmd_done,
  input wire logic [ADDR_W:0]   loader_end_boundary,
  input wire logic              fuses_loaded
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Assertions
  refuse_quiet_a: assert property (req_refused |-> !cmd_valid && !cpu_halt)
    else $error("refusal came with a command or halt");
  eeprom_no_halt_a: assert property (cmd_valid && cmd.op == FSG_OP_EEPROM |-> !cpu_halt)
    else $error("eeprom write halted the processor");
  erase_page_a: assert property (cmd_valid && cmd.op == FSG_OP_ERASE |-> cmd.addr[8:0] == 9'h000)
    else $error("erase not page aligned");
  take_answer_a: assert property (req_valid && req_ready |=> cmd_valid != req_refused)
    else $error("taken request got no single answer");
  same_section_a: assert property (req_valid && req_ready && req.op != FSG_OP_EEPROM
    && fetch_addr < loader_end_boundary && req.addr < loader_end_boundary |=> req_refused)
    else $error("write into own loader section allowed");
  // Exact boundary only for fuses that fit the array
  loader_end_a: assert property (fuses_loaded && loader_size_fuse != 8'h00 && loader_size_fuse <= 8'h40
    |-> loader_end_boundary == {loader_size_fuse, 9'h000})
    else $error("loader end boundary wrong");
  halt_release_a: assert property (cmd_valid && cmd_done |=> !cmd_valid && !cpu_halt)
    else $error("halt held after done");
  busy_ready_a: assert property (cmd_valid |-> !req_ready)
    else $error("ready while busy");
endmodule // fsg_guard_props

/* test/fsg_array_model.sv */
// Flash array stand-in answering each command after a set delay
`timescale 1ns/1ps
module fsg_array_model
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Command handshake
  input  wire logic       cmd_valid,
  input  wire logic [3:0] done_delay,
  output logic            cmd_done
);
  logic [3:0] wait_q;
  // ==========================================================
  // One done pulse per command; long delays keep the guard busy
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_q   <= 4'h0;
      cmd_done <= 1'b0;
    end
    else
    begin
      cmd_done <= cmd_valid && !cmd_done && (wait_q >= done_delay);
      wait_q   <= (cmd_valid && !cmd_done) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // fsg_array_model

/* test/fsg_guard_tb.sv */
// Self-checking bench for the flash section write guard
`timescale 1ns/1ps
module fsg_guard_tb
  import fsg_pkg::*;
;
  // Stimulus and observed signals
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [FUSE_W-1:0] lfuse   = 8'h00;
  logic [FUSE_W-1:0] cfuse   = 8'h00;
  logic [ADDR_W-1:0] fetch   = 15'h0000;
  logic              vsel    = 1'b0;
  logic              rv      = 1'b0;
  fsg_req_s          rq      = '0;
  logic [3:0]        dly     = 4'h0;
  logic              wsel    = 1'b1;
  logic              rdy, refd, halt, cv, done, fl;
  logic [ADDR_W-1:0] vbase;
  fsg_cmd_s          cmd;
  logic [ADDR_W:0]   le, ce;
  int                n_mismatch = 0;
  int                compares   = 0;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  fsg_guard DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .loader_size_fuse(lfuse), .code_region_size_fuse(cfuse),
    .fetch_addr(fetch), .vector_table_select(vsel), .req_valid(rv), .req(rq), .req_ready(rdy),
    .req_refused(refd), .cpu_halt(halt), .vector_base(vbase), .cmd_valid(cv), .cmd(cmd), .cmd_done(done),
    .loader_end_boundary(le), .code_end_boundary(ce), .fuses_loaded(fl));
  fsg_array_model u_array (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cv), .done_delay(dly), .cmd_done(done));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Fuses only count when sampled after reset, so each partition needs one
  task automatic do_reset(input logic [7:0] l, input logic [7:0] c);
    sys_rst = 1'b1;
    lfuse = l;
    cfuse = c;
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // Present one request, then judge answer, halt, command fields and release
  // Erase asks for zero pages so the one-page floor is exercised
  task automatic try_req(input fsg_op_e op, input logic [14:0] f, input logic [14:0] a, input logic ok);
    int          n;
    logic [14:0] ea;
    logic [5:0]  ep;
    ea = (op == FSG_OP_ERASE) ? (a & 15'h7e00) : (op == FSG_OP_WRITE && wsel) ? (a & 15'h7ffe) : a;
    ep = (op == FSG_OP_ERASE) ? 6'h01 : 6'h02;
    n = 0;
    fetch = f;
    rq = '{op: op, addr: a, wdata: 16'h5aa5, word: wsel, pages: (op == FSG_OP_ERASE) ? 6'h00 : 6'h02};
    rv = 1'b1;
    while (rdy !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(rdy, 1'b1, "request taken");
    @(negedge sys_clk);
    rv = 1'b0;
    chk(cv, ok, "command issued");
    chk(refd, !ok, "refusal flag");
    chk(halt, ok && op != FSG_OP_EEPROM, "processor halt");
    if (ok)
    begin
      chk({1'b0, cmd.addr}, {1'b0, ea}, "command address");
      chk({13'h0000, cmd.op}, {13'h0000, op}, "command kind");
      chk({10'h000, cmd.pages}, {10'h000, ep}, "erase pages");
      chk({15'h0000, cmd.word}, {15'h0000, wsel}, "write width");
      chk(cmd.wdata, 16'h5aa5, "command data");
    end
    // Limit reached counts as a failure through the compare below
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (cv === 1'b1 && n < 50);
    chk(cv, 1'b0, "command finished");
    chk(halt, 1'b0, "halt released");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_partition;
    do_reset(8'h04, 8'h08);
    chk(le, 16'h0800, "loader end");
    chk(ce, 16'h1000, "code end");
    chk(fl, 1'b1, "partition loaded");
    chk(vbase, 15'h0800, "vectors at code start");
    vsel = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(vbase, 15'h0000, "vectors at loader start");
    vsel = 1'b0;
    try_req(FSG_OP_WRITE, 15'h0100, 15'h0011, 1'b0);
    try_req(FSG_OP_WRITE, 15'h0100, 15'h0901, 1'b1);
    try_req(FSG_OP_ERASE, 15'h0100, 15'h2123, 1'b1);
    try_req(FSG_OP_EEPROM, 15'h0100, 15'h0010, 1'b1);
    try_req(FSG_OP_WRITE, 15'h0900, 15'h0a00, 1'b0);
    try_req(FSG_OP_ERASE, 15'h0900, 15'h0000, 1'b0);
    try_req(FSG_OP_WRITE, 15'h0900, 15'h1000, 1'b1);
    try_req(FSG_OP_EEPROM, 15'h0900, 15'h0010, 1'b1);
    try_req(FSG_OP_WRITE, 15'h1000, 15'h2000, 1'b0);
    try_req(FSG_OP_EEPROM, 15'h1000, 15'h0010, 1'b0);
    $display("test partition done");
  endtask
  // Slow array answers while fuse corner cases are walked
  task automatic t_sizes;
    dly = 4'h6;
    do_reset(8'h04, 8'h00);
    chk(ce, 16'h8000, "code end at flash end");
    try_req(FSG_OP_WRITE, 15'h0100, 15'h7f00, 1'b1);
    wsel = 1'b0;
    try_req(FSG_OP_WRITE, 15'h0100, 15'h7f01, 1'b1);
    wsel = 1'b1;
    try_req(FSG_OP_WRITE, 15'h7f00, 15'h7000, 1'b0);
    do_reset(8'h04, 8'h03);
    chk(le, 16'h0800, "loader end no code");
    chk(ce, 16'h0800, "no code section");
    try_req(FSG_OP_EEPROM, 15'h0900, 15'h0010, 1'b0);
    try_req(FSG_OP_WRITE, 15'h0100, 15'h7000, 1'b1);
    do_reset(8'h00, 8'h08);
    chk(le, 16'h8000, "whole flash loader");
    chk(vbase, 15'h0000, "vectors with no code");
    try_req(FSG_OP_WRITE, 15'h0100, 15'h7000, 1'b0);
    do_reset(8'h50, 8'h08);
    chk(le, 16'h8000, "loader overrun default");
    try_req(FSG_OP_WRITE, 15'h0100, 15'h7000, 1'b0);
    do_reset(8'h04, 8'h50);
    chk(le, 16'h0800, "loader kept");
    chk(ce, 16'h8000, "code overrun default");
    try_req(FSG_OP_WRITE, 15'h0100, 15'h7000, 1'b1);
    try_req(FSG_OP_EEPROM, 15'h7000, 15'h0010, 1'b1);
    $display("test sizes done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    t_partition();
    t_sizes();
    tally_and_finish();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial
  begin
    #50000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // fsg_guard_tb
bind fsg_guard fsg_guard_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .loader_size_fuse(loader_size_fuse),
  .fetch_addr(fetch_addr), .req_valid(req_valid), .req(req), .req_ready(req_ready), .req_refused(req_refused),
  .cpu_halt(cpu_halt), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_done(cmd_done),
  .loader_end_boundary(loader_end_boundary), .fuses_loaded(fuses_loaded));
